//--- rtl/ptpts_pkg.sv
// Constants and carrier types for the per-port PTP timestamp register bank.
// How it works
// - Receive wire latency is a 16-bit writable nanosecond value, reset 415.
// - Transmit wire latency is a 16-bit writable nanosecond value, reset 45.
// - Asymmetry is sign and magnitude; bit 15 set means negative; resets zero.
// - Ingress Sync and Pdelay_Resp get the signed asymmetry added to correction.
// - Egress Delay_Req and Pdelay_Req get the signed asymmetry subtracted.
// - Request egress timestamp, 32 bits, shown as two read-only halves, reset zero.
// - Upper half of the last Sync egress timestamp is read-only.
// - Lower half of the Sync egress timestamp is a separate read-only register.
// - Upper half of the Pdelay_Resp egress timestamp is read-only, reset zero.
// - Lower half of the Pdelay_Resp timestamp sits two words after the upper.
// - Each capture sets a write-one-to-clear flag; flags OR into a port event.
// - A writable 32-bit link delay in nanoseconds describes the partner delay.
package ptpts_pkg;

    localparam int ADDR_W = 16;
    localparam int IDX_W  = 14;
    localparam int CF_W   = 64;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [IDX_W-1:0] IDX_RX_LAT    = 14'h0c00;
    localparam logic [IDX_W-1:0] IDX_TX_LAT    = 14'h0c02;
    localparam logic [IDX_W-1:0] IDX_ASYM      = 14'h0c04;
    localparam logic [IDX_W-1:0] IDX_REQ_HI    = 14'h0c08;
    localparam logic [IDX_W-1:0] IDX_REQ_LO    = 14'h0c0a;
    localparam logic [IDX_W-1:0] IDX_SYNC_HI   = 14'h0c0c;
    localparam logic [IDX_W-1:0] IDX_SYNC_LO   = 14'h0c0e;
    localparam logic [IDX_W-1:0] IDX_RESP_HI   = 14'h0c10;
    localparam logic [IDX_W-1:0] IDX_RESP_LO   = 14'h0c12;
    localparam logic [IDX_W-1:0] IDX_STATUS    = 14'h0c14;
    localparam logic [IDX_W-1:0] IDX_MASK      = 14'h0c16;
    localparam logic [IDX_W-1:0] IDX_LINK_DLY  = 14'h0c18;

    localparam logic [15:0] RX_LAT_RESET   = 16'h019f;
    localparam logic [15:0] TX_LAT_RESET   = 16'h002d;
    localparam logic [15:0] ASYM_RESET     = 16'h0000;
    localparam logic [15:0] TIME_RESET     = 16'h0000;
    localparam logic [15:0] FLAG_RESET     = 16'h0000;
    localparam logic [31:0] LINK_DLY_RESET = 32'h0000_0000;

    localparam int ASYM_SIGN_BIT = 15;
    localparam int ASYM_MAG_W    = 15;
    localparam int CF_FRAC_BITS  = 16;

    localparam int FLAG_SYNC = 15;
    localparam int FLAG_REQ  = 14;
    localparam int FLAG_RESP = 13;
    localparam logic [15:0] FLAG_MASK = 16'he000;

    localparam logic [3:0] MSG_SYNC        = 4'h0;
    localparam logic [3:0] MSG_DELAY_REQ   = 4'h1;
    localparam logic [3:0] MSG_PDELAY_REQ  = 4'h2;
    localparam logic [3:0] MSG_PDELAY_RESP = 4'h3;

    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    // One egress timestamp report from the transmit path.
    typedef struct packed {
        logic        valid;
        logic [3:0]  msg;
        logic [31:0] ns;
    } ptpts_stamp_t;

    // One correction field to adjust; cf is in nanoseconds scaled by 2^16.
    typedef struct packed {
        logic            valid;
        logic            egress;
        logic [3:0]      msg;
        logic [CF_W-1:0] cf;
    } ptpts_corr_t;

endpackage

//--- rtl/ptpts_port_regs.sv
// Per-port PTP latency, asymmetry and egress timestamp registers behind AXI4-Lite.
//
// The AXI4-Lite register port is this design's own decision.
module ptpts_port_regs
    import ptpts_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
    input  wire logic              i_s_axi_awvalid,
    output wire logic              o_s_axi_awready,
    input  wire logic [31:0]       i_s_axi_wdata,
    input  wire logic [3:0]        i_s_axi_wstrb,
    input  wire logic              i_s_axi_wvalid,
    output wire logic              o_s_axi_wready,
    output wire logic [1:0]        o_s_axi_bresp,
    output wire logic              o_s_axi_bvalid,
    input  wire logic              i_s_axi_bready,
    input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
    input  wire logic              i_s_axi_arvalid,
    output wire logic              o_s_axi_arready,
    output wire logic [31:0]       o_s_axi_rdata,
    output wire logic [1:0]        o_s_axi_rresp,
    output wire logic              o_s_axi_rvalid,
    input  wire logic              i_s_axi_rready,
    input  wire ptpts_stamp_t      i_stamp,
    input  wire ptpts_corr_t       i_corr,
    output wire ptpts_corr_t       o_corr,
    output wire logic [15:0]       o_rx_wire_latency,
    output wire logic [15:0]       o_tx_wire_latency,
    output wire logic [31:0]       o_link_delay,
    output wire logic              o_ts_event,
    output wire logic              o_irq
);

    function automatic logic [31:0] merge32(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Write channel holding registers: address and data may arrive in either order.
    logic                 aw_have_reg;
    logic [IDX_W-1:0]     aw_idx_reg;
    logic                 w_have_reg;
    logic [31:0]          wdata_reg;
    logic [3:0]           wstrb_reg;
    logic                 bvalid_reg;
    logic [1:0]           bresp_reg;
    logic                 rvalid_reg;
    logic [1:0]           rresp_reg;
    logic [31:0]          rdata_reg;

    // Bank contents.
    logic [15:0]          rx_lat_reg;
    logic [15:0]          tx_lat_reg;
    logic [15:0]          asym_reg;
    logic [31:0]          req_time_reg;
    logic [31:0]          sync_time_reg;
    logic [31:0]          resp_time_reg;
    logic [15:0]          status_reg;
    logic [15:0]          status_next;
    logic [15:0]          mask_reg;
    logic [31:0]          link_dly_reg;
    ptpts_corr_t          corr_reg;

    assign o_s_axi_awready = !aw_have_reg && !bvalid_reg;
    assign o_s_axi_wready  = !w_have_reg && !bvalid_reg;
    assign o_s_axi_bvalid  = bvalid_reg;
    assign o_s_axi_bresp   = bresp_reg;
    assign o_s_axi_arready = !rvalid_reg;
    assign o_s_axi_rvalid  = rvalid_reg;
    assign o_s_axi_rresp   = rresp_reg;
    assign o_s_axi_rdata   = rdata_reg;

    wire aw_take  = i_s_axi_awvalid && o_s_axi_awready;
    wire w_take   = i_s_axi_wvalid && o_s_axi_wready;
    wire wr_fire  = aw_have_reg && w_have_reg && !bvalid_reg;
    wire ar_take  = i_s_axi_arvalid && o_s_axi_arready;

    // Write decode.
    wire wr_rx    = wr_fire && (aw_idx_reg == IDX_RX_LAT);
    wire wr_tx    = wr_fire && (aw_idx_reg == IDX_TX_LAT);
    wire wr_asym  = wr_fire && (aw_idx_reg == IDX_ASYM);
    wire wr_stat  = wr_fire && (aw_idx_reg == IDX_STATUS);
    wire wr_mask  = wr_fire && (aw_idx_reg == IDX_MASK);
    wire wr_link  = wr_fire && (aw_idx_reg == IDX_LINK_DLY);
    wire wr_ro    = (aw_idx_reg == IDX_REQ_HI) || (aw_idx_reg == IDX_REQ_LO)
                 || (aw_idx_reg == IDX_SYNC_HI) || (aw_idx_reg == IDX_SYNC_LO)
                 || (aw_idx_reg == IDX_RESP_HI) || (aw_idx_reg == IDX_RESP_LO);
    // Writes to read-only words are accepted and dropped, so they answer OKAY.
    wire wr_hit   = wr_ro || (aw_idx_reg == IDX_RX_LAT) || (aw_idx_reg == IDX_TX_LAT)
                 || (aw_idx_reg == IDX_ASYM) || (aw_idx_reg == IDX_STATUS)
                 || (aw_idx_reg == IDX_MASK) || (aw_idx_reg == IDX_LINK_DLY);
    wire [31:0] wr_merged_lo = merge32(32'h0000_0000, wdata_reg, wstrb_reg);

    // Read decode; narrow registers sit in the low bits and the rest read zero.
    wire [IDX_W-1:0] rd_idx = i_s_axi_araddr[ADDR_W-1:2];
    wire rd_rx    = (rd_idx == IDX_RX_LAT);
    wire rd_tx    = (rd_idx == IDX_TX_LAT);
    wire rd_asym  = (rd_idx == IDX_ASYM);
    wire rd_reqh  = (rd_idx == IDX_REQ_HI);
    wire rd_reql  = (rd_idx == IDX_REQ_LO);
    wire rd_synh  = (rd_idx == IDX_SYNC_HI);
    wire rd_synl  = (rd_idx == IDX_SYNC_LO);
    wire rd_resh  = (rd_idx == IDX_RESP_HI);
    wire rd_resl  = (rd_idx == IDX_RESP_LO);
    wire rd_stat  = (rd_idx == IDX_STATUS);
    wire rd_mask  = (rd_idx == IDX_MASK);
    wire rd_link  = (rd_idx == IDX_LINK_DLY);
    wire rd_hit   = rd_rx || rd_tx || rd_asym || rd_reqh || rd_reql || rd_synh
                 || rd_synl || rd_resh || rd_resl || rd_stat || rd_mask || rd_link;
    wire [15:0] rd_half = ({16{rd_rx}}   & rx_lat_reg)
                        | ({16{rd_tx}}   & tx_lat_reg)
                        | ({16{rd_asym}} & asym_reg)
                        | ({16{rd_reqh}} & req_time_reg[31:16])
                        | ({16{rd_reql}} & req_time_reg[15:0])
                        | ({16{rd_synh}} & sync_time_reg[31:16])
                        | ({16{rd_synl}} & sync_time_reg[15:0])
                        | ({16{rd_resh}} & resp_time_reg[31:16])
                        | ({16{rd_resl}} & resp_time_reg[15:0])
                        | ({16{rd_stat}} & status_reg)
                        | ({16{rd_mask}} & mask_reg);
    wire [31:0] rd_word = rd_link ? link_dly_reg : {16'h0000, rd_half};

    // Capture events from the transmit path.
    wire cap_sync = i_stamp.valid && (i_stamp.msg == MSG_SYNC);
    wire cap_req  = i_stamp.valid && ((i_stamp.msg == MSG_DELAY_REQ)
                                   || (i_stamp.msg == MSG_PDELAY_REQ));
    wire cap_resp = i_stamp.valid && (i_stamp.msg == MSG_PDELAY_RESP);

    wire [15:0] flag_set = ({15'h0000, cap_sync} << FLAG_SYNC)
                         | ({15'h0000, cap_req}  << FLAG_REQ)
                         | ({15'h0000, cap_resp} << FLAG_RESP);
    wire [15:0] flag_clr = wr_stat ? (wr_merged_lo[15:0] & FLAG_MASK) : 16'h0000;
    // A capture in the same cycle as a clear keeps its flag set.
    assign status_next = (status_reg & ~flag_clr) | flag_set;

    // Asymmetry scaled into correction-field units, signed by bit 15.
    wire [ASYM_MAG_W-1:0] asym_mag = asym_reg[ASYM_MAG_W-1:0];
    wire [CF_W-1:0] asym_scaled = {{(CF_W-ASYM_MAG_W-CF_FRAC_BITS){1'b0}}, asym_mag,
                                   {CF_FRAC_BITS{1'b0}}};
    wire [CF_W-1:0] asym_delta  = asym_reg[ASYM_SIGN_BIT] ? (~asym_scaled + 64'h0000_0000_0000_0001)
                                                          : asym_scaled;
    wire corr_add = !i_corr.egress && ((i_corr.msg == MSG_SYNC)
                                    || (i_corr.msg == MSG_PDELAY_RESP));
    wire corr_sub = i_corr.egress && ((i_corr.msg == MSG_DELAY_REQ)
                                   || (i_corr.msg == MSG_PDELAY_REQ));
    wire [CF_W-1:0] cf_next = corr_add ? (i_corr.cf + asym_delta)
                            : corr_sub ? (i_corr.cf - asym_delta)
                            : i_corr.cf;

    assign o_corr            = corr_reg;
    assign o_rx_wire_latency = rx_lat_reg;
    assign o_tx_wire_latency = tx_lat_reg;
    assign o_link_delay      = link_dly_reg;
    assign o_ts_event        = |status_reg;
    assign o_irq             = |(status_reg & mask_reg);

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            aw_have_reg <= 1'b0;
            aw_idx_reg  <= '0;
            w_have_reg  <= 1'b0;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= AXI_OKAY;
        end else begin
            if (aw_take) begin
                aw_have_reg <= 1'b1;
                aw_idx_reg  <= i_s_axi_awaddr[ADDR_W-1:2];
            end
            if (w_take) begin
                w_have_reg <= 1'b1;
                wdata_reg  <= i_s_axi_wdata;
                wstrb_reg  <= i_s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_reg <= 1'b0;
                w_have_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_hit ? AXI_OKAY : AXI_SLVERR;
            end else if (bvalid_reg && i_s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= AXI_OKAY;
            rdata_reg  <= 32'h0000_0000;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
            rdata_reg  <= rd_hit ? rd_word : 32'h0000_0000;
        end else if (rvalid_reg && i_s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rx_lat_reg   <= RX_LAT_RESET;
            tx_lat_reg   <= TX_LAT_RESET;
            asym_reg     <= ASYM_RESET;
            mask_reg     <= FLAG_RESET;
            link_dly_reg <= LINK_DLY_RESET;
        end else begin
            if (wr_rx) begin
                rx_lat_reg <= wr_merged_lo[15:0] | (rx_lat_reg & ~merge32(32'h0000_0000,
                              32'hffff_ffff, wstrb_reg)[15:0]);
            end
            if (wr_tx) begin
                tx_lat_reg <= merge32({16'h0000, tx_lat_reg}, wdata_reg, wstrb_reg)[15:0];
            end
            if (wr_asym) begin
                asym_reg <= merge32({16'h0000, asym_reg}, wdata_reg, wstrb_reg)[15:0];
            end
            if (wr_mask) begin
                mask_reg <= merge32({16'h0000, mask_reg}, wdata_reg, wstrb_reg)[15:0]
                            & FLAG_MASK;
            end
            if (wr_link) begin
                link_dly_reg <= merge32(link_dly_reg, wdata_reg, wstrb_reg);
            end
        end
    end

    // Whole 32-bit words are stored in one edge, so halves never mix frames.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            req_time_reg  <= {TIME_RESET, TIME_RESET};
            sync_time_reg <= {TIME_RESET, TIME_RESET};
            resp_time_reg <= {TIME_RESET, TIME_RESET};
            status_reg    <= FLAG_RESET;
            corr_reg      <= '0;
        end else begin
            if (cap_req) begin
                req_time_reg <= i_stamp.ns;
            end
            if (cap_sync) begin
                sync_time_reg <= i_stamp.ns;
            end
            if (cap_resp) begin
                resp_time_reg <= i_stamp.ns;
            end
            status_reg      <= status_next;
            corr_reg.valid  <= i_corr.valid;
            corr_reg.egress <= i_corr.egress;
            corr_reg.msg    <= i_corr.msg;
            corr_reg.cf     <= cf_next;
        end
    end

    rx_reset_a: assert property (@(posedge i_clk) !i_rstn |=> rx_lat_reg == RX_LAT_RESET)
        else $error("Receive latency did not reset to 415.");
    tx_reset_a: assert property (@(posedge i_clk) !i_rstn |=> tx_lat_reg == TX_LAT_RESET)
        else $error("Transmit latency did not reset to 45.");
    asym_reset_a: assert property (@(posedge i_clk) !i_rstn |=> asym_reg == ASYM_RESET)
        else $error("Asymmetry did not reset to zero.");
    corr_add_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (!i_corr.egress && i_corr.msg == MSG_SYNC && !wr_asym)
        |=> o_corr.cf == $past(i_corr.cf) + (asym_reg[ASYM_SIGN_BIT]
            ? -asym_scaled : asym_scaled))
        else $error("Ingress correction was not increased by the asymmetry.");
    corr_sub_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_corr.egress && i_corr.msg == MSG_DELAY_REQ && !wr_asym)
        |=> o_corr.cf == $past(i_corr.cf) - (asym_reg[ASYM_SIGN_BIT]
            ? -asym_scaled : asym_scaled))
        else $error("Egress correction was not reduced by the asymmetry.");
    req_capture_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        cap_req |=> req_time_reg == $past(i_stamp.ns) && status_reg[FLAG_REQ])
        else $error("Request timestamp or flag was not captured.");
    sync_capture_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        cap_sync |=> sync_time_reg == $past(i_stamp.ns) && status_reg[FLAG_SYNC])
        else $error("Sync timestamp or flag was not captured.");
    resp_capture_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        cap_resp |=> resp_time_reg == $past(i_stamp.ns) && status_reg[FLAG_RESP])
        else $error("Peer response timestamp or flag was not captured.");
    flag_event_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (status_reg[FLAG_SYNC] && !wr_stat) |=> status_reg[FLAG_SYNC] && o_ts_event)
        else $error("Sync flag dropped without a clear.");
    link_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (wr_link && wstrb_reg == 4'hf) |=> link_dly_reg == $past(wdata_reg))
        else $error("Link delay write was not stored.");
    halves_same_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $changed(sync_time_reg[15:0]) |-> $past(cap_sync))
        else $error("Sync low half changed without a capture.");

endmodule

//--- verification/ptpts_port_regs_tb_top.sv
// Self-checking bench for the per-port PTP timestamp register bank.
module ptpts_port_regs_tb_top import ptpts_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic              i_clk;
    logic              i_rstn;
    logic [ADDR_W-1:0] i_s_axi_awaddr;
    logic              i_s_axi_awvalid;
    logic [31:0]       i_s_axi_wdata;
    logic [3:0]        i_s_axi_wstrb;
    logic              i_s_axi_wvalid;
    logic              i_s_axi_bready;
    logic [ADDR_W-1:0] i_s_axi_araddr;
    logic              i_s_axi_arvalid;
    logic              i_s_axi_rready;
    ptpts_stamp_t      i_stamp;
    ptpts_corr_t       i_corr;
    wire logic         o_s_axi_awready;
    wire logic         o_s_axi_wready;
    wire logic [1:0]   o_s_axi_bresp;
    wire logic         o_s_axi_bvalid;
    wire logic         o_s_axi_arready;
    wire logic [31:0]  o_s_axi_rdata;
    wire logic [1:0]   o_s_axi_rresp;
    wire logic         o_s_axi_rvalid;
    wire ptpts_corr_t  o_corr;
    wire logic [15:0]  o_rx_wire_latency;
    wire logic [15:0]  o_tx_wire_latency;
    wire logic [31:0]  o_link_delay;
    wire logic         o_ts_event;
    wire logic         o_irq;
    int                err_total;
    int                samples_checked;
    logic [31:0]       rnd;
    logic [31:0]       sh [12];
    logic [15:0]       asym_tab [5];

    // Shadow index order: latencies, asymmetry, three stamp pairs, status, mask, link delay.
    localparam logic [IDX_W-1:0] IDX_TAB [12] = '{IDX_RX_LAT, IDX_TX_LAT, IDX_ASYM, IDX_REQ_HI,
        IDX_REQ_LO, IDX_SYNC_HI, IDX_SYNC_LO, IDX_RESP_HI, IDX_RESP_LO, IDX_STATUS, IDX_MASK,
        IDX_LINK_DLY};

    ptpts_port_regs i_dut (
        .i_clk, .i_rstn, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata,
        .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid,
        .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata,
        .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_stamp, .i_corr, .o_corr,
        .o_rx_wire_latency, .o_tx_wire_latency, .o_link_delay, .o_ts_event, .o_irq
    );

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // The magnitude sits at the nanosecond point of the scaled correction field.
    function automatic logic [63:0] exp_cf(input logic eg, input logic [3:0] m,
                                           input logic [63:0] cf, input logic [15:0] a);
        logic [63:0] d;
        d = {33'h0_0000_0000, a[14:0], 16'h0000};
        if (a[ASYM_SIGN_BIT]) d = -d;
        if (!eg && (m == MSG_SYNC || m == MSG_PDELAY_RESP)) return cf + d;
        if (eg && (m == MSG_DELAY_REQ || m == MSG_PDELAY_REQ)) return cf - d;
        return cf;
    endfunction

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic timed_out();
        err_total++;
        $display("MISMATCH bus answer expected response seen timeout");
        give_verdict();
    endtask

    // A response that never comes would hang the run, so every wait is bounded.
    task automatic axi_write(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
        int   n;
        logic got;
        got = 1'b0;
        n = 0;
        r = 2'h3;
        @(posedge i_clk);
        i_s_axi_awaddr <= a;
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_wdata <= d;
        i_s_axi_wvalid <= 1'b1;
        i_s_axi_bready <= 1'b1;
        while (!got && n < 64) begin
            @(posedge i_clk);
            n++;
            if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
            if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
            if (o_s_axi_bvalid) begin
                got = 1'b1;
                r = o_s_axi_bresp;
                i_s_axi_bready <= 1'b0;
            end
        end
        if (!got) timed_out();
    endtask

    task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        int   n;
        logic got;
        got = 1'b0;
        n = 0;
        r = 2'h3;
        d = 32'hdead_beef;
        @(posedge i_clk);
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1'b1;
        i_s_axi_rready <= 1'b1;
        while (!got && n < 64) begin
            @(posedge i_clk);
            n++;
            if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
            if (o_s_axi_rvalid) begin
                got = 1'b1;
                d = o_s_axi_rdata;
                r = o_s_axi_rresp;
                i_s_axi_rready <= 1'b0;
            end
        end
        if (!got) timed_out();
    endtask

    task automatic wr(input int i, input logic [31:0] d);
        logic [1:0] r;
        axi_write({IDX_TAB[i], 2'b00}, d, r);
        check("bresp", {62'h0, r}, {62'h0, AXI_OKAY});
        case (i)
            0, 1, 2: sh[i] = {16'h0000, d[15:0]};
            9: sh[9] = sh[9] & ~(d & {16'h0000, FLAG_MASK});
            10: sh[10] = d & {16'h0000, FLAG_MASK};
            11: sh[11] = d;
            default: ;
        endcase
    endtask

    task automatic verify_all();
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 12; i++) begin
            axi_read({IDX_TAB[i], 2'b00}, d, r);
            check($sformatf("reg%0d", i), {32'h0, d}, {32'h0, sh[i]});
            check("rresp", {62'h0, r}, {62'h0, AXI_OKAY});
        end
        check("rx_out", {48'h0, o_rx_wire_latency}, {32'h0, sh[0]});
        check("tx_out", {48'h0, o_tx_wire_latency}, {32'h0, sh[1]});
        check("link_out", {32'h0, o_link_delay}, {32'h0, sh[11]});
        check("ts_event", {63'h0, o_ts_event}, {63'h0, |sh[9]});
        check("irq", {63'h0, o_irq}, {63'h0, |(sh[9] & sh[10])});
    endtask

    // Valid stays up between calls so that stamps can arrive on consecutive cycles.
    task automatic stamp(input logic [3:0] m, input logic [31:0] v);
        int k;
        int f;
        @(posedge i_clk);
        i_stamp <= '{valid: 1'b1, msg: m, ns: v};
        k = (m == MSG_SYNC) ? 5 : (m == MSG_PDELAY_RESP) ? 7 : 3;
        f = (m == MSG_SYNC) ? FLAG_SYNC : (m == MSG_PDELAY_RESP) ? FLAG_RESP : FLAG_REQ;
        sh[k] = {16'h0000, v[31:16]};
        sh[k+1] = {16'h0000, v[15:0]};
        sh[9][f] = 1'b1;
    endtask

    task automatic stamp_end();
        @(posedge i_clk);
        i_stamp.valid <= 1'b0;
    endtask

    task automatic corr(input logic eg, input logic [3:0] m, input logic [63:0] cf);
        @(posedge i_clk);
        i_corr <= '{valid: 1'b1, egress: eg, msg: m, cf: cf};
        @(posedge i_clk);
        @(posedge i_clk);
        check("corr_cf", o_corr.cf, exp_cf(eg, m, cf, sh[2][15:0]));
        check("corr_valid", {63'h0, o_corr.valid}, 64'h1);
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        err_total = 0;
        samples_checked = 0;
        rnd = 32'h0000_0057;
        {i_rstn, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} = 4'h0;
        {i_s_axi_arvalid, i_s_axi_rready} = 2'h0;
        {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = '0;
        i_s_axi_wstrb = 4'hf;
        i_stamp = '0;
        i_corr = '0;
        foreach (sh[i]) sh[i] = 32'h0000_0000;
        sh[0] = {16'h0000, RX_LAT_RESET};
        sh[1] = {16'h0000, TX_LAT_RESET};
        repeat (6) @(posedge i_clk);
        i_rstn <= 1'b1;
        verify_all();
        for (int k = 0; k < 24; k++) begin
            rnd = lfsr_next(rnd);
            wr(int'(rnd[3:0]) % 12, lfsr_next(rnd));
            if (k % 3 == 0) begin
                stamp({2'b00, rnd[9:8]}, rnd ^ 32'h5a5a_a5a5);
                stamp_end();
            end
        end
        verify_all();
        // Unmapped words answer with an error and leave every register alone.
        axi_write({14'h0c06, 2'b00}, 32'hffff_ffff, r);
        check("bresp_unmapped", {62'h0, r}, {62'h0, AXI_SLVERR});
        axi_read({14'h0000, 2'b00}, d, r);
        check("rresp_unmapped", {62'h0, r}, {62'h0, AXI_SLVERR});
        check("rdata_unmapped", {32'h0, d}, 64'h0);
        for (int i = 3; i < 9; i++) wr(i, 32'hffff_ffff);
        rnd = lfsr_next(rnd);
        stamp(MSG_DELAY_REQ, rnd);
        stamp(MSG_PDELAY_REQ, ~rnd);
        stamp(MSG_SYNC, {rnd[15:0], rnd[31:16]});
        stamp(MSG_PDELAY_RESP, rnd + 32'h0001_0001);
        stamp_end();
        wr(10, 32'h0000_e000);
        verify_all();
        wr(9, 32'h0000_8000);
        wr(10, 32'h0000_2000);
        verify_all();
        wr(9, 32'h0000_2000);
        verify_all();
        wr(9, 32'hffff_ffff);
        verify_all();
        asym_tab = '{rnd[15:0], 16'h7fff, 16'h8001, 16'hffff, 16'h0000};
        foreach (asym_tab[j]) begin
            wr(2, {16'h0000, asym_tab[j]});
            for (int m = 0; m < 5; m++) begin
                rnd = lfsr_next(rnd);
                corr(1'b0, m[3:0], {rnd, lfsr_next(rnd)});
                corr(1'b1, m[3:0], {lfsr_next(rnd), rnd});
            end
        end
        give_verdict();
    end
endmodule
